// file: hw/can_mode_pkg.sv
// shared constants and types of the transceiver mode controller
package can_mode_pkg;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  localparam int CLK_MHZ                  = 40;
  localparam int POWER_ON_TIME_US         = 100;
  localparam int SLEEP_TIME_US            = 50;
  localparam int IO_REF_UNDERVOLT_LONG_US = 200;
  localparam int CORE_UNDERVOLT_LONG_US   = 200;
  // exact products at 40 MHz, so rounding up or down gives the same count
  localparam int POWER_ON_CYCLES          = POWER_ON_TIME_US * CLK_MHZ;
  localparam int SLEEP_CYCLES             = SLEEP_TIME_US * CLK_MHZ;
  localparam int IO_UV_LONG_CYCLES        = IO_REF_UNDERVOLT_LONG_US * CLK_MHZ;
  localparam int CORE_UV_LONG_CYCLES      = CORE_UNDERVOLT_LONG_US * CLK_MHZ;
  localparam int TIMER_W                  = 16;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_STATUS  = 2'h0;
  localparam logic [1:0] REG_CONTROL = 2'h1;
  localparam int ADR_W               = 4;

  localparam int ST_MODE_LSB         = 0;
  localparam int ST_MODE_W           = 3;
  localparam int ST_POR_FLAG         = 3;
  localparam int ST_BUS_WAKE         = 4;
  localparam int ST_LOCAL_WAKE       = 5;
  localparam int ST_SLEEP_EXPIRED    = 6;
  localparam int ST_FROM_NORMAL      = 7;
  localparam int CTL_CLEAR_POR       = 0;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0008;

  // ----------------------------------------------------------------
  // modes and pin bundle
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_POR,
    MODE_NORMAL,
    MODE_RX_ONLY,
    MODE_STANDBY,
    MODE_GO_TO_SLEEP,
    MODE_SLEEP
  } mode_type;

  typedef struct packed {
    logic tx_enable;
    logic tx_data;
    logic rxd;
    logic rxd_en_n;
    logic error_out_n;
    logic error_out_n_en_n;
    logic inhibit_en_n;
    logic receiver_en;
    logic lp_receiver_en;
    logic local_wake_en;
    logic protection_en;
    logic bat_uv_det_en;
    logic core_uv_det_en;
    logic io_uv_det_en;
  } pin_out_type;

  localparam pin_out_type PINS_RESET = '{
    tx_enable: 1'b0, tx_data: 1'b1, rxd: 1'b1, rxd_en_n: 1'b1,
    error_out_n: 1'b1, error_out_n_en_n: 1'b1, inhibit_en_n: 1'b0,
    receiver_en: 1'b0, lp_receiver_en: 1'b0, local_wake_en: 1'b0,
    protection_en: 1'b0, bat_uv_det_en: 1'b0, core_uv_det_en: 1'b0,
    io_uv_det_en: 1'b0};

endpackage : can_mode_pkg

// file: hw/can_transceiver_mode_control.sv
// mode controller of a high-speed can transceiver with wishbone status port
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.

// Summary of operation
// - receive-only: transmitter off, transmit input ignored, receiver drives rxd.
// - select low with standby_not high enters receive-only when supplies good.
// - receive-only entered from a low-power mode shows power-up flag on error pin.
// - receive-only entered from normal reports core undervoltage on error pin.
// - stand-by: transmitter off, low-power receiver only, outputs high without wake.
// - stand-by: local wake active, inhibit connected, local failure report off.
// - after reset, supply good for power-on time enters stand-by; pins need io ok.
// - any wake in sleep or go-to-sleep moves the device to stand-by.
// - both pins low from normal or receive-only enters stand-by.
// - standby_not low with select high enters go-to-sleep from awake modes.
// - go-to-sleep runs sleep timer; sleep at expiry only without wake or flag.
// - go-to-sleep keeps inhibit connected while timer runs, wake or flag set.
// - sleep is reached by pins only through go-to-sleep.
// - select falling before sleep timer expiry returns to stand-by, inhibit kept.
// - bus level never blocks or delays a mode change.
// - sleep: inhibit floats, local wake active, only io undervoltage detection on.
// - long io or core undervoltage plus bus silence forces sleep.
// - sleep: standby_not rising enters normal if select high, else receive-only.
// - sleep ignores select alone; leaves for stand-by only on a wake.
// - power-on reset disables all functions, blocks inputs, floats rxd and error.
// - power-on reset sets power-on flag, then stand-by within power-on time.
// - both pins high enter normal mode with supplies and io in range.
// - select pins act on transitions, not on continuously sampled levels.
// - bus wake drives rxd and error low; local wake only drives rxd low.
module can_transceiver_mode_control #(
  parameter int IO_UV_LONG_CYCLES   = can_mode_pkg::IO_UV_LONG_CYCLES,
  parameter int CORE_UV_LONG_CYCLES = can_mode_pkg::CORE_UV_LONG_CYCLES
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [can_mode_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          mode_select_i,
  input  wire logic                          standby_not_pin_i,
  input  wire logic                          txd_i,
  input  wire logic                          bus_rx_i,
  input  wire logic                          bus_wake_pattern_i,
  input  wire logic                          local_wake_event_i,
  input  wire logic                          bat_ok_i,
  input  wire logic                          core_ok_i,
  input  wire logic                          io_ok_i,
  input  wire logic                          silence_expired_i,
  input  wire logic                          local_failure_i,
  output logic                               tx_enable_o,
  output logic                               tx_data_o,
  output logic                               rxd_o,
  output logic                               rxd_en_n_o,
  output logic                               error_out_n_o,
  output logic                               error_out_n_en_n_o,
  output logic                               inhibit_switch_out_o,
  output logic                               inhibit_switch_out_en_n_o,
  output logic                               receiver_en_o,
  output logic                               lp_receiver_en_o,
  output logic                               local_wake_en_o,
  output logic                               protection_en_o,
  output logic                               bat_uv_det_en_o,
  output logic                               core_uv_det_en_o,
  output logic                               io_uv_det_en_o,
  output logic      [2:0]                    mode_o
);

  // ----------------------------------------------------------------
  // pin synchronisers and event detection
  // ----------------------------------------------------------------
  logic sel_meta, sel_sync, sel_prev;
  logic standby_not_pin_meta, standby_not_pin_sync, standby_not_pin_prev;

  always_ff @(posedge clk_i) begin
    sel_meta  <= mode_select_i;
    sel_sync  <= sel_meta;
    sel_prev  <= sel_sync;
    standby_not_pin_meta <= standby_not_pin_i;
    standby_not_pin_sync <= standby_not_pin_meta;
    standby_not_pin_prev <= standby_not_pin_sync;
  end

  can_mode_pkg::mode_type mode, next_mode;

  wire supply_ok   = bat_ok_i | core_ok_i;
  // inputs blocked without io reference or supply, and during power-on reset
  wire pins_live   = io_ok_i & supply_ok & (mode != can_mode_pkg::MODE_POR);
  wire sel_edge    = (sel_sync ^ sel_prev) & pins_live;
  wire standby_not_pin_edge   = (standby_not_pin_sync ^ standby_not_pin_prev) & pins_live;
  wire standby_not_pin_rise   = standby_not_pin_edge & standby_not_pin_sync;
  wire sel_fall    = sel_edge & ~sel_sync;
  wire pin_event   = sel_edge | standby_not_pin_edge;

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  logic [can_mode_pkg::TIMER_W-1:0] pon_cnt, sleep_cnt, io_uv_cnt, core_uv_cnt;
  logic                             sleep_expired;

  localparam logic [can_mode_pkg::TIMER_W-1:0] PON_LAST =
    can_mode_pkg::TIMER_W'(can_mode_pkg::POWER_ON_CYCLES - 1);
  localparam logic [can_mode_pkg::TIMER_W-1:0] SLEEP_LAST =
    can_mode_pkg::TIMER_W'(can_mode_pkg::SLEEP_CYCLES - 1);
  localparam logic [can_mode_pkg::TIMER_W-1:0] IO_UV_LAST =
    can_mode_pkg::TIMER_W'(IO_UV_LONG_CYCLES - 1);
  localparam logic [can_mode_pkg::TIMER_W-1:0] CORE_UV_LAST =
    can_mode_pkg::TIMER_W'(CORE_UV_LONG_CYCLES - 1);

  wire in_gts      = (mode == can_mode_pkg::MODE_GO_TO_SLEEP);
  wire pon_done    = (pon_cnt == PON_LAST);
  wire sleep_done  = in_gts & (sleep_cnt == SLEEP_LAST);
  // long-term timers armed only while battery is good
  wire io_uv_long  = (io_uv_cnt == IO_UV_LAST);
  wire core_uv_long = (core_uv_cnt == CORE_UV_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || mode != can_mode_pkg::MODE_POR || !supply_ok) begin
      pon_cnt <= '0;
    end else if (!pon_done) begin
      pon_cnt <= pon_cnt + 1'b1;
    end
    if (rst_i || !in_gts) begin
      sleep_cnt     <= '0;
      sleep_expired <= 1'b0;
    end else if (sleep_done) begin
      sleep_expired <= 1'b1;
    end else if (!sleep_expired) begin
      sleep_cnt <= sleep_cnt + 1'b1;
    end
    if (rst_i || io_ok_i || !bat_ok_i) begin
      io_uv_cnt <= '0;
    end else if (!io_uv_long) begin
      io_uv_cnt <= io_uv_cnt + 1'b1;
    end
    if (rst_i || core_ok_i || !bat_ok_i) begin
      core_uv_cnt <= '0;
    end else if (!core_uv_long) begin
      core_uv_cnt <= core_uv_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  logic por_flag, bus_wake, local_wake, from_normal;
  logic clear_por;

  wire low_power   = (mode == can_mode_pkg::MODE_STANDBY) | in_gts |
                     (mode == can_mode_pkg::MODE_SLEEP);
  wire wake_pend   = bus_wake | local_wake;
  wire wake_now    = bus_wake_pattern_i | local_wake_event_i;
  wire entering_awake = ((next_mode == can_mode_pkg::MODE_NORMAL) |
                         (next_mode == can_mode_pkg::MODE_RX_ONLY)) &
                        (next_mode != mode);

  always_ff @(posedge clk_i) begin
    if (rst_i || mode == can_mode_pkg::MODE_POR) begin
      por_flag    <= 1'b1;
      bus_wake    <= 1'b0;
      local_wake  <= 1'b0;
      from_normal <= 1'b0;
    end else begin
      // software clear loses against nothing here: hardware only sets in por
      if (clear_por) begin
        por_flag <= 1'b0;
      end
      // a wake arriving while the flag is cleared on wake-up is kept
      bus_wake   <= (bus_wake & ~entering_awake) |
                    (bus_wake_pattern_i & low_power);
      local_wake <= (local_wake & ~entering_awake) |
                    (local_wake_event_i & low_power & bat_ok_i);
      if (next_mode == can_mode_pkg::MODE_RX_ONLY &&
          mode != can_mode_pkg::MODE_RX_ONLY) begin
        from_normal <= (mode == can_mode_pkg::MODE_NORMAL);
      end
    end
  end

  // ----------------------------------------------------------------
  // mode state machine; bus level is no input to it
  // ----------------------------------------------------------------
  // target mode chosen from the pin levels at an event
  can_mode_pkg::mode_type pin_target;
  always_comb begin
    case ({sel_sync, standby_not_pin_sync})
      2'b11:   pin_target = can_mode_pkg::MODE_NORMAL;
      2'b01:   pin_target = can_mode_pkg::MODE_RX_ONLY;
      2'b00:   pin_target = can_mode_pkg::MODE_STANDBY;
      default: pin_target = can_mode_pkg::MODE_GO_TO_SLEEP;
    endcase
  end

  wire uv_to_sleep = (io_uv_long | core_uv_long) & silence_expired_i;

  always_comb begin
    next_mode = mode;
    case (mode)
      can_mode_pkg::MODE_POR: begin
        if (supply_ok && pon_done) begin
          next_mode = can_mode_pkg::MODE_STANDBY;
        end
      end
      can_mode_pkg::MODE_NORMAL, can_mode_pkg::MODE_RX_ONLY,
      can_mode_pkg::MODE_STANDBY: begin
        if (uv_to_sleep) begin
          next_mode = can_mode_pkg::MODE_SLEEP;
        end else if (pin_event) begin
          next_mode = pin_target;
        end
      end
      can_mode_pkg::MODE_GO_TO_SLEEP: begin
        if (wake_now || wake_pend) begin
          next_mode = can_mode_pkg::MODE_STANDBY;
        end else if (uv_to_sleep) begin
          next_mode = can_mode_pkg::MODE_SLEEP;
        end else if (standby_not_pin_rise) begin
          next_mode = pin_target;
        end else if (sel_fall && !sleep_expired) begin
          next_mode = can_mode_pkg::MODE_STANDBY;
        end else if (sleep_done && !por_flag && !standby_not_pin_sync) begin
          next_mode = can_mode_pkg::MODE_SLEEP;
        end
      end
      can_mode_pkg::MODE_SLEEP: begin
        if (wake_now) begin
          next_mode = can_mode_pkg::MODE_STANDBY;
        end else if (standby_not_pin_rise) begin
          next_mode = sel_sync ? can_mode_pkg::MODE_NORMAL
                               : can_mode_pkg::MODE_RX_ONLY;
        end
      end
      default: next_mode = can_mode_pkg::MODE_POR;
    endcase
    // loss of both supplies overrides everything
    if (!supply_ok) begin
      next_mode = can_mode_pkg::MODE_POR;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= can_mode_pkg::MODE_POR;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // per-mode pin behaviour
  // ----------------------------------------------------------------
  can_mode_pkg::pin_out_type pins, next_pins;

  always_comb begin
    next_pins = can_mode_pkg::PINS_RESET;
    case (mode)
      can_mode_pkg::MODE_NORMAL: begin
        next_pins.tx_enable        = core_ok_i;
        next_pins.tx_data          = txd_i | ~io_ok_i;
        next_pins.rxd              = bus_rx_i;
        next_pins.rxd_en_n         = 1'b0;
        next_pins.error_out_n      = ~(local_failure_i | ~core_ok_i);
        next_pins.error_out_n_en_n = 1'b0;
        next_pins.receiver_en      = 1'b1;
        next_pins.protection_en    = 1'b1;
        next_pins.bat_uv_det_en    = 1'b1;
        next_pins.core_uv_det_en   = 1'b1;
        next_pins.io_uv_det_en     = 1'b1;
      end
      can_mode_pkg::MODE_RX_ONLY: begin
        next_pins.tx_enable        = 1'b0;
        next_pins.rxd              = bus_rx_i;
        next_pins.rxd_en_n         = 1'b0;
        next_pins.error_out_n      = from_normal ? core_ok_i
                                                 : ~por_flag;
        next_pins.error_out_n_en_n = 1'b0;
        next_pins.receiver_en      = 1'b1;
        next_pins.bat_uv_det_en    = 1'b1;
        next_pins.core_uv_det_en   = 1'b1;
        next_pins.io_uv_det_en     = 1'b1;
      end
      can_mode_pkg::MODE_STANDBY, can_mode_pkg::MODE_GO_TO_SLEEP,
      can_mode_pkg::MODE_SLEEP: begin
        next_pins.tx_enable        = 1'b0;
        next_pins.rxd              = ~wake_pend;
        next_pins.error_out_n      = ~bus_wake;
        next_pins.lp_receiver_en   = 1'b1;
        next_pins.local_wake_en    = 1'b1;
        next_pins.io_uv_det_en     = 1'b1;
        // in sleep the outputs hold only with io reference present
        next_pins.rxd_en_n         = (mode == can_mode_pkg::MODE_SLEEP) &
                                     ~io_ok_i;
        next_pins.error_out_n_en_n = next_pins.rxd_en_n;
        next_pins.bat_uv_det_en    = (mode != can_mode_pkg::MODE_SLEEP);
        next_pins.core_uv_det_en   = (mode != can_mode_pkg::MODE_SLEEP);
        if (mode == can_mode_pkg::MODE_SLEEP) begin
          next_pins.inhibit_en_n   = 1'b1;
        end else if (mode == can_mode_pkg::MODE_GO_TO_SLEEP) begin
          next_pins.inhibit_en_n   = sleep_expired & ~wake_pend &
                                     ~por_flag;
        end
      end
      default: begin
        // power-on reset: inhibit follows supply presence
        next_pins.inhibit_en_n     = ~supply_ok;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins <= can_mode_pkg::PINS_RESET;
    end else begin
      pins <= next_pins;
    end
  end

  assign tx_enable_o               = pins.tx_enable;
  assign tx_data_o                 = pins.tx_data;
  assign rxd_o                     = pins.rxd;
  assign rxd_en_n_o                = pins.rxd_en_n;
  assign error_out_n_o             = pins.error_out_n;
  assign error_out_n_en_n_o        = pins.error_out_n_en_n;
  assign inhibit_switch_out_o      = 1'b1;
  assign inhibit_switch_out_en_n_o = pins.inhibit_en_n;
  assign receiver_en_o             = pins.receiver_en;
  assign lp_receiver_en_o          = pins.lp_receiver_en;
  assign local_wake_en_o           = pins.local_wake_en;
  assign protection_en_o           = pins.protection_en;
  assign bat_uv_det_en_o           = pins.bat_uv_det_en;
  assign core_uv_det_en_o          = pins.core_uv_det_en;
  assign io_uv_det_en_o            = pins.io_uv_det_en;
  assign mode_o                    = mode;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  wire       bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [1:0] reg_index = wb_adr_i[3:2];
  wire       hit_stat  = (reg_index == can_mode_pkg::REG_STATUS);
  wire       hit_ctl   = (reg_index == can_mode_pkg::REG_CONTROL);
  assign clear_por     = bus_req & wb_we_i & hit_ctl & wb_sel_i[0] &
                         wb_dat_i[can_mode_pkg::CTL_CLEAR_POR];

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[can_mode_pkg::ST_MODE_LSB +: can_mode_pkg::ST_MODE_W] = mode;
    status_word[can_mode_pkg::ST_POR_FLAG]      = por_flag;
    status_word[can_mode_pkg::ST_BUS_WAKE]      = bus_wake;
    status_word[can_mode_pkg::ST_LOCAL_WAKE]    = local_wake;
    status_word[can_mode_pkg::ST_SLEEP_EXPIRED] = sleep_expired;
    status_word[can_mode_pkg::ST_FROM_NORMAL]   = from_normal;
  end

  wire [31:0] read_word = hit_stat ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= read_word;
      end
    end
  end

endmodule : can_transceiver_mode_control

// file: tb/can_mode_props.sv
// port assertions of the transceiver mode controller
module can_mode_props #(
  parameter int IO_UV_LONG_CYCLES   = can_mode_pkg::IO_UV_LONG_CYCLES,
  parameter int CORE_UV_LONG_CYCLES = can_mode_pkg::CORE_UV_LONG_CYCLES
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       mode_select_i,
  input wire logic       standby_not_pin_i,
  input wire logic       bus_wake_pattern_i,
  input wire logic       io_ok_i,
  input wire logic       core_ok_i,
  input wire logic       tx_enable_o,
  input wire logic       rxd_o,
  input wire logic       rxd_en_n_o,
  input wire logic       error_out_n_o,
  input wire logic       error_out_n_en_n_o,
  input wire logic       inhibit_switch_out_en_n_o,
  input wire logic       receiver_en_o,
  input wire logic       lp_receiver_en_o,
  input wire logic       local_wake_en_o,
  input wire logic       bat_uv_det_en_o,
  input wire logic       core_uv_det_en_o,
  input wire logic       io_uv_det_en_o,
  input wire logic [2:0] mode_o
);
  int gts_cnt;
  int uv_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // dwell counters, slack of a few cycles covers pin-to-mode latency
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    gts_cnt <= (rst_i || mode_o != 3'h4) ? 0 : gts_cnt + 1;
    uv_cnt  <= (rst_i || (io_ok_i && core_ok_i)) ? 0 : uv_cnt + 1;
  end
  sequence gts_request;
    mode_o == 3'h3 && !mode_select_i && !standby_not_pin_i
    ##1 (io_ok_i && mode_select_i && !standby_not_pin_i) [*6];
  endsequence
  sequence early_fall;
    mode_o == 3'h4 && gts_cnt < 1900 && mode_select_i
    ##1 (io_ok_i && !mode_select_i && !standby_not_pin_i) [*6];
  endsequence
  gts_entry_a: assert property (gts_request |-> mode_o == 3'h4)
    else $error("go-to-sleep not entered");
  early_fall_a: assert property (early_fall |-> mode_o == 3'h3)
    else $error("select fall did not give stand-by");
  sleep_entry_a: assert property ($changed(mode_o) && mode_o == 3'h5 |->
    ($past(mode_o) == 3'h4 && gts_cnt >= 1995) ||
    uv_cnt >= IO_UV_LONG_CYCLES - 2) else $error("early sleep entry");
  wake_exit_a: assert property ((mode_o == 3'h5 || mode_o == 3'h4) &&
    bus_wake_pattern_i |=> mode_o == 3'h3) else $error("wake ignored");
  rx_only_a: assert property (mode_o == 3'h2 && $past(mode_o) == 3'h2
    |-> !tx_enable_o && receiver_en_o) else $error("rx-only outputs");
  standby_a: assert property (mode_o == 3'h3 && $past(mode_o) == 3'h3
    |-> !tx_enable_o && lp_receiver_en_o && local_wake_en_o &&
    !inhibit_switch_out_en_n_o) else $error("stand-by outputs");
  sleep_out_a: assert property (mode_o == 3'h5 && $past(mode_o) == 3'h5
    |-> inhibit_switch_out_en_n_o && local_wake_en_o && !bat_uv_det_en_o
    && !core_uv_det_en_o && io_uv_det_en_o) else $error("sleep outputs");
  por_out_a: assert property (mode_o == 3'h0 && $past(mode_o) == 3'h0
    |-> rxd_en_n_o && error_out_n_en_n_o && !tx_enable_o && !receiver_en_o
    && !local_wake_en_o) else $error("reset outputs");
  bus_wake_a: assert property (mode_o == 3'h3 && $past(mode_o) == 3'h3
    && !error_out_n_o |-> !rxd_o) else $error("bus wake rxd high");
endmodule : can_mode_props

bind can_transceiver_mode_control can_mode_props #(
  .IO_UV_LONG_CYCLES  (IO_UV_LONG_CYCLES),
  .CORE_UV_LONG_CYCLES(CORE_UV_LONG_CYCLES)
) u_props (.*);

// file: tb/can_host_model.sv
// host controller model driving the mode select pins and transmit data
module can_host_model (
  input  wire logic clk_i,
  output logic      mode_select_o,
  output logic      standby_not_o,
  output logic      txd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int seed = 32'hbfe0d303;
  initial begin
    mode_select_o = 1'b0;
    standby_not_o = 1'b0;
    txd_o = 1'b1;
  end
  always @(posedge clk_i) txd_o <= $random(seed);
  // sleep is only ever asked for through the go-to-sleep pin pair
  task automatic set_pins(input logic s, input logic n);
    @(posedge clk_i);
    mode_select_o <= s;
    standby_not_o <= n;
    repeat (8) @(posedge clk_i);
  endtask : set_pins
endmodule : can_host_model

// file: tb/can_transceiver_mode_control_tb.sv
// self-checking bench of the transceiver mode controller
module can_transceiver_mode_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, we = 1'b0, wake = 1'b0, sil = 1'b0, brx = 1'b1;
  logic        bat = 1'b1, core = 1'b1, io = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic        ack, sel, standby_not_pin, txd, rxd, err, inhibit_switch_out, txo;
  logic [2:0]  mode;
  int          fail_count = 0, checks = 0, em = 0, seed = 32'hbfe0d303;
  logic        pn = 1'b0, lwk = 1'b0;
  can_host_model u_host (.clk_i(clk_i), .mode_select_o(sel),
    .standby_not_o(standby_not_pin), .txd_o(txd));
  can_transceiver_mode_control #(.IO_UV_LONG_CYCLES(40),
    .CORE_UV_LONG_CYCLES(40)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mode_select_i(sel), .standby_not_pin_i(standby_not_pin), .txd_i(txd),
    .bus_rx_i(brx), .bus_wake_pattern_i(wake), .local_wake_event_i(lwk),
    .bat_ok_i(bat), .core_ok_i(core), .io_ok_i(io),
    .silence_expired_i(sil), .local_failure_i(1'b0), .tx_enable_o(),
    .tx_data_o(txo), .rxd_o(rxd), .rxd_en_n_o(), .error_out_n_o(err),
    .error_out_n_en_n_o(), .inhibit_switch_out_o(),
    .inhibit_switch_out_en_n_o(inhibit_switch_out), .receiver_en_o(),
    .lp_receiver_en_o(), .local_wake_en_o(), .protection_en_o(),
    .bat_uv_det_en_o(), .core_uv_det_en_o(), .io_uv_det_en_o(),
    .mode_o(mode));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // a random bus level must never hold up a mode change
  always @(posedge clk_i) brx <= $random(seed);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : wb
  // reference mode model: pin events per mode, sleep waits for standby_not_pin rise
  task automatic step(input logic s, input logic n);
    u_host.set_pins(s, n);
    if (em == 5) em = (n && !pn) ? (s ? 1 : 2) : 5;
    else if (s && !n) em = 4;
    else if (!n) em = 3;
    else em = s ? 1 : 2;
    pn = n;
    chk(mode, em);
  endtask : step
  task automatic stop_test;
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic to_sleep;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    repeat (2010) @(posedge clk_i);
    em = 5;
    chk(mode, em);
    chk(inhibit_switch_out, 1'b1);
  endtask : to_sleep
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(mode, 3'h0);
    repeat (4010) @(posedge clk_i);
    em = 3;
    chk(mode, em);
    wb(1'b0, 4'h0, 32'h0);
    chk(rd, 32'hb);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 4'h4, 32'h1);
    wb(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h3);
    step(1'b0, 1'b1);
    chk(txo, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    chk(inhibit_switch_out, 1'b0);
    to_sleep();
    step(1'b1, 1'b0);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    repeat (3) @(posedge clk_i);
    em = 3;
    chk({mode, rxd, err}, {3'h3, 2'b00});
    step(1'b0, 1'b1);
    to_sleep();
    step(1'b1, 1'b1);
    io <= 1'b0;
    sil <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk(mode, 3'h5);
    io <= 1'b1;
    sil <= 1'b0;
    // local wake alone: rxd low, error pin stays high
    lwk <= 1'b1;
    @(posedge clk_i);
    lwk <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({mode, rxd, err}, {3'h3, 2'b01});
    bat <= 1'b0;
    core <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(mode, 3'h0);
    bat <= 1'b1;
    core <= 1'b1;
    repeat (4010) @(posedge clk_i);
    chk(mode, 3'h3);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end
endmodule : can_transceiver_mode_control_tb
